// [design/trim_cal.sv]
// quad channel zero and gain trim registers with axi4-lite access
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module trim_cal
	import trim_cal_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [ADDR_BITS-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [ADDR_BITS-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_load,
	output logic [CHANNELS-1:0][CODE_W-1:0] o_code,
	output logic [CHANNELS-1:0] o_sat
);
	if (CHANNELS != 4) begin : g_chan_check
		$error("trim_cal serves exactly four channels");
	end

	// ---------------------------------------------------------------
	// trim arithmetic
	// ---------------------------------------------------------------
	// result is {saturated, code}; code in eighths of an lsb
	function automatic logic [CODE_W:0] trim_code(input logic [DATA_W-1:0] d,
			input logic [ZERO_W-1:0] z, input logic [GAIN_W-1:0] g, input logic bip);
		logic signed [16:0] s;
		logic signed [24:0] p;
		logic signed [21:0] t;
		logic signed [21:0] hi;
		logic signed [21:0] lo;
		s = bip ? $signed({d[15], d}) : $signed({1'b0, d});
		p = s * $signed(g);
		t = (22'(s) <<< FRAC_W) + 22'(p >>> GAIN_SHIFT) + 22'($signed(z));
		hi = bip ? BIP_MAX : UNI_MAX;
		lo = bip ? BIP_MIN : UNI_MIN;
		if (t > hi) begin
			trim_code = {1'b1, hi[CODE_W-1:0]};
		end else if (t < lo) begin
			trim_code = {1'b1, lo[CODE_W-1:0]};
		end else begin
			trim_code = {1'b0, t[CODE_W-1:0]};
		end
	endfunction : trim_code

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
		end
	endfunction : merge

	function automatic logic is_mapped(input logic [ADDR_BITS-1:0] a);
		is_mapped = (a[1:0] == 2'b00) && (a[ADDR_BITS-1:2] <= IDX_STATUS);
	endfunction : is_mapped

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] data_q [CHANNELS];
	logic [DATA_W-1:0] latch_q [CHANNELS];
	logic [ZERO_W-1:0] zero_q [CHANNELS];
	logic [GAIN_W-1:0] gain_q [CHANNELS];
	logic bipolar_q;
	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [ADDR_BITS-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [CHANNELS-1:0][CODE_W-1:0] code_q;
	logic [CHANNELS-1:0] sat_q;

	// ---------------------------------------------------------------
	// write channel decode
	// ---------------------------------------------------------------
	// address and data may arrive in either order; each is parked until the other comes
	wire aw_take = i_awvalid && o_awready;
	wire w_take = i_wvalid && o_wready;
	wire have_aw = aw_hold_q || aw_take;
	wire have_w = w_hold_q || w_take;
	wire wr_fire = have_aw && have_w;
	wire [ADDR_BITS-1:0] wr_addr = aw_hold_q ? awaddr_q : i_awaddr;
	wire [31:0] wr_data = w_hold_q ? wdata_q : i_wdata;
	wire [3:0] wr_strb = w_hold_q ? wstrb_q : i_wstrb;
	wire [3:0] wr_idx = wr_addr[5:2];
	wire wr_ok = is_mapped(wr_addr);
	assign o_awready = !aw_hold_q && !bvalid_q;
	assign o_wready = !w_hold_q && !bvalid_q;
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;

	always_ff @(posedge i_mclk) begin
		if (i_rst || wr_fire) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
		end else begin
			aw_hold_q <= aw_hold_q || aw_take;
			w_hold_q <= w_hold_q || w_take;
		end
		if (aw_take) begin
			awaddr_q <= i_awaddr;
		end
		if (w_take) begin
			wdata_q <= i_wdata;
			wstrb_q <= i_wstrb;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (i_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	// reserved bits are never stored, so they read back as zero
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			for (int c = 0; c < CHANNELS; c++) begin
				data_q[c] <= DATA_RESET;
				zero_q[c] <= ZERO_RESET;
				gain_q[c] <= GAIN_RESET;
			end
			bipolar_q <= 1'b0;
		end else if (wr_fire && wr_ok) begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (wr_idx == IDX_DATA0 + 4'(c)) begin
					data_q[c] <= DATA_W'(merge(32'(data_q[c]), wr_data, wr_strb));
				end
				if (wr_idx == IDX_ZERO0 + 4'(c)) begin
					zero_q[c] <= ZERO_W'(merge(32'(zero_q[c]), wr_data, wr_strb));
				end
				if (wr_idx == IDX_GAIN0 + 4'(c)) begin
					gain_q[c] <= GAIN_W'(merge(32'(gain_q[c]), wr_data, wr_strb));
				end
			end
			if (wr_idx == IDX_CONFIG && wr_strb[0]) begin
				bipolar_q <= wr_data[CFG_BIPOLAR_BIT];
			end
		end
	end

	// ---------------------------------------------------------------
	// read channel
	// ---------------------------------------------------------------
	wire ar_take = i_arvalid && o_arready;
	wire [3:0] rd_idx = i_araddr[5:2];
	wire [1:0] rd_ch = rd_idx[1:0];
	wire rd_ok = is_mapped(i_araddr);
	wire [31:0] rd_word =
		!rd_ok ? 32'h0000_0000 :
		(rd_idx < IDX_ZERO0) ? 32'(data_q[rd_ch]) :
		(rd_idx < IDX_GAIN0) ? 32'(zero_q[rd_ch]) :
		(rd_idx < IDX_CONFIG) ? 32'(gain_q[rd_ch]) :
		(rd_idx == IDX_CONFIG) ? 32'(bipolar_q) : 32'(sat_q);
	assign o_arready = !rvalid_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (i_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// output datapath
	// ---------------------------------------------------------------
	// trims are applied every cycle, so a trim write alone moves the output
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			for (int c = 0; c < CHANNELS; c++) begin
				latch_q[c] <= DATA_RESET;
			end
			code_q <= '0;
			sat_q <= '0;
		end else begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (i_load) begin
					latch_q[c] <= data_q[c];
				end
				{sat_q[c], code_q[c]} <= trim_code(latch_q[c], zero_q[c], gain_q[c],
					bipolar_q);
			end
		end
	end
	assign o_code = code_q;
	assign o_sat = sat_q;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	logic past_rst_q;
	always_ff @(posedge i_mclk) begin
		past_rst_q <= i_rst;
	end
	wire zero1_wr = wr_fire && wr_ok && (wr_idx == IDX_ZERO0 + 4'd1);
	wire gain2_wr = wr_fire && wr_ok && (wr_idx == IDX_GAIN0 + 4'd2);
	wire [CODE_W:0] ch0_trim = trim_code(latch_q[0], zero_q[0], gain_q[0], bipolar_q);

	reset_gain_clear_a: assert property (past_rst_q |-> gain_q[3] == 8'h00 && gain_q[0] == 8'h00)
		else $error("gain trim not zero after reset");
	reset_zero_clear_a: assert property (past_rst_q |-> zero_q[2] == 9'h000 && zero_q[1] == 9'h000)
		else $error("zero trim not zero after reset");
	channel_isolation_a: assert property ($changed(zero_q[1]) |-> $past(zero1_wr))
		else $error("zero trim 1 changed without its own write");
	gain_isolation_a: assert property ($changed(gain_q[2]) |-> $past(gain2_wr))
		else $error("gain trim 2 changed without its own write");
	reserved_read_a: assert property (ar_take && rd_ok && rd_idx >= IDX_ZERO0 && rd_idx < IDX_CONFIG
		|=> o_rdata[31:9] == 23'h0 && ($past(rd_idx) < IDX_GAIN0 || o_rdata[8] == 1'b0))
		else $error("reserved trim bits read nonzero");
	zero_max_step_a: assert property (latch_q[0] == 16'h0000 && zero_q[0] == 9'h0FF
		&& gain_q[0] == 8'h00 && !bipolar_q |=> o_code[0] == 19'd255)
		else $error("zero trim +31.875 lsb not applied");
	zero_min_step_a: assert property (latch_q[1] == 16'h0100 && zero_q[1] == 9'h100
		&& gain_q[1] == 8'h00 && !bipolar_q |=> o_code[1] == 19'd1792)
		else $error("zero trim -32 lsb not applied");
	gain_neg_unipolar_a: assert property (latch_q[2] == 16'h8000 && gain_q[2] == 8'h80
		&& zero_q[2] == 9'h000 && !bipolar_q |=> o_code[2] == 19'h3_FE00)
		else $error("gain trim -128 lsb wrong in unipolar mode");
	gain_pos_bipolar_a: assert property (latch_q[3] == 16'h4000 && gain_q[3] == 8'h7F
		&& zero_q[3] == 9'h000 && bipolar_q |=> o_code[3] == 19'h2_00FE)
		else $error("gain trim +127 lsb wrong in bipolar mode");
	trim_follows_a: assert property ($changed(zero_q[0]) && !i_load
		|=> o_code[0] == $past(ch0_trim[CODE_W-1:0], 1))
		else $error("new zero trim not applied to held data");
	bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped before bready");

	trim_write_c: cover property (zero1_wr ##1 o_bvalid);
	split_write_c: cover property (aw_take && !w_take ##[1:4] w_take);
	sat_hit_c: cover property (o_sat != '0);
	bad_addr_c: cover property (o_rvalid && o_rresp == RESP_SLVERR);
endmodule : trim_cal

// [design/trim_cal_pkg.sv]
// constants for the per-channel zero and gain trim block
package trim_cal_pkg;
	// ---------------------------------------------------------------
	// register word indexes (byte address = index * 4)
	// ---------------------------------------------------------------
	localparam logic [3:0] IDX_DATA0 = 4'h0;
	localparam logic [3:0] IDX_ZERO0 = 4'h4;
	localparam logic [3:0] IDX_GAIN0 = 4'h8;
	localparam logic [3:0] IDX_CONFIG = 4'hC;
	localparam logic [3:0] IDX_STATUS = 4'hD;
	localparam int ADDR_BITS = 6;
	// ---------------------------------------------------------------
	// field layout and reset values
	// ---------------------------------------------------------------
	localparam int ZERO_W = 9;
	localparam int GAIN_W = 8;
	localparam int DATA_W = 16;
	localparam int FRAC_W = 3;
	localparam int CODE_W = DATA_W + FRAC_W;
	localparam int GAIN_SHIFT = DATA_W - FRAC_W;
	localparam int CFG_BIPOLAR_BIT = 0;
	localparam logic [ZERO_W-1:0] ZERO_RESET = 9'h000;
	localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ---------------------------------------------------------------
	// saturation limits in eighths of an lsb
	// ---------------------------------------------------------------
	localparam logic signed [21:0] UNI_MAX = 22'sh07_FFFF;
	localparam logic signed [21:0] UNI_MIN = 22'sh00_0000;
	localparam logic signed [21:0] BIP_MAX = 22'sh03_FFFF;
	localparam logic signed [21:0] BIP_MIN = -22'sh04_0000;
endpackage : trim_cal_pkg

// [verification/trim_host.sv]
// axi4-lite host model that reaches the trim block registers
module trim_host
	import trim_cal_pkg::*;
(
	input wire logic i_mclk,
	output logic [ADDR_BITS-1:0] o_awaddr,
	output logic o_awvalid,
	input wire logic i_awready,
	output logic [31:0] o_wdata,
	output logic [3:0] o_wstrb,
	output logic o_wvalid,
	input wire logic i_wready,
	input wire logic i_bvalid,
	input wire logic [1:0] i_bresp,
	output logic o_bready,
	output logic [ADDR_BITS-1:0] o_araddr,
	output logic o_arvalid,
	input wire logic i_arready,
	input wire logic i_rvalid,
	input wire logic [31:0] i_rdata,
	input wire logic [1:0] i_rresp,
	output logic o_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// bus cycles
	// --------
	// ready held high: this host never stalls an answer
	initial begin
		o_awaddr = '0;
		o_awvalid = 1'b0;
		o_wdata = '0;
		o_wstrb = 4'hF;
		o_wvalid = 1'b0;
		o_bready = 1'b1;
		o_araddr = '0;
		o_arvalid = 1'b0;
		o_rready = 1'b1;
	end
	// released payload is inverted so stale values cannot pass
	task automatic wr(input logic [ADDR_BITS-1:0] a, input logic [31:0] d,
		output logic [1:0] r, output bit ok);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		ok = 0;
		r = 2'h3;
		o_awaddr <= a;
		o_wdata <= d;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		for (int n = 0; n < 64 && !ok; n++) begin
			@(posedge i_mclk);
			if (!aw && i_awready) begin
				aw = 1;
				o_awvalid <= 1'b0;
				o_awaddr <= ~a;
			end
			if (!w && i_wready) begin
				w = 1;
				o_wvalid <= 1'b0;
				o_wdata <= ~d;
			end
			if (i_bvalid) begin
				ok = 1;
				r = i_bresp;
			end
		end
	endtask : wr
	task automatic rd(input logic [ADDR_BITS-1:0] a, output logic [31:0] d,
		output logic [1:0] r, output bit ok);
		bit ar;
		ar = 0;
		ok = 0;
		d = '0;
		r = 2'h3;
		o_araddr <= a;
		o_arvalid <= 1'b1;
		for (int n = 0; n < 64 && !ok; n++) begin
			@(posedge i_mclk);
			if (!ar && i_arready) begin
				ar = 1;
				o_arvalid <= 1'b0;
				o_araddr <= ~a;
			end
			if (i_rvalid) begin
				ok = 1;
				d = i_rdata;
				r = i_rresp;
			end
		end
	endtask : rd
endmodule : trim_host

// [verification/trim_cal_tb_top.sv]
// self-checking bench for the quad channel trim block
module trim_cal_tb_top
	import trim_cal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst, load, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, bip;
	logic [ADDR_BITS-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb, sat;
	logic [1:0] bresp, rresp, r;
	logic [3:0][CODE_W-1:0] code;
	logic [31:0] seed = 32'h0000_005F;
	logic [8:0] zq [4];
	logic [7:0] gq [4];
	logic [15:0] dq [4];
	bit ok;
	int fails = 0;
	int checks = 0;
	trim_cal trim_cal_inst (.i_mclk(mclk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_load(load),
		.o_code(code), .o_sat(sat));
	trim_host trim_host_inst (.i_mclk(mclk), .o_awaddr(awaddr), .o_awvalid(awvalid),
		.i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
		.i_wready(wready), .i_bvalid(bvalid), .i_bresp(bresp), .o_bready(bready),
		.o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rvalid(rvalid),
		.i_rdata(rdata), .i_rresp(rresp), .o_rready(rready));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// --------
	// helpers
	// --------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// eighths of an lsb; gain product shifted arithmetically, then clamped
	function automatic logic [31:0] exp_code(logic [15:0] d, logic [8:0] z, logic [7:0] g);
		longint dv;
		longint p;
		longint hi;
		longint lo;
		dv = bip ? longint'($signed(d)) : longint'(d);
		p = dv * 8 + ((dv * longint'($signed(g))) >>> 13) + longint'($signed(z));
		hi = bip ? longint'(BIP_MAX) : longint'(UNI_MAX);
		lo = bip ? longint'(BIP_MIN) : longint'(UNI_MIN);
		p = (p > hi) ? hi : ((p < lo) ? lo : p);
		return {13'h0000, p[18:0]};
	endfunction : exp_code
	function automatic logic [5:0] adr(logic [3:0] idx, int c);
		return {idx + 4'(c), 2'b00};
	endfunction : adr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	task automatic put(input logic [5:0] a, input logic [31:0] d);
		trim_host_inst.wr(a, d, r, ok);
		if (!ok) begin
			fails++;
			close_out();
		end
	endtask : put
	task automatic get(input logic [5:0] a);
		trim_host_inst.rd(a, v, r, ok);
		if (!ok) begin
			fails++;
			close_out();
		end
	endtask : get
	// --------
	// main sequence
	// --------
	initial begin
		rst = 1'b1;
		load = 1'b0;
		bip = 1'b0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (int c = 0; c < 4; c++) begin
			get(adr(IDX_ZERO0, c));
			chk(v, 32'h0000_0000);
			get(adr(IDX_GAIN0, c));
			chk(v, 32'h0000_0000);
			chk({13'h0000, code[c]}, 32'h0000_0000);
		end
		$display("test reset values done");
		for (int c = 0; c < 4; c++) begin
			v = rnd();
			zq[c] = v[8:0];
			gq[c] = v[31:24];
			put(adr(IDX_ZERO0, c), {23'h7F_FFFF, zq[c]});
			put(adr(IDX_GAIN0, c), {24'hFF_FFFF, gq[c]});
		end
		for (int c = 0; c < 4; c++) begin
			get(adr(IDX_ZERO0, c));
			chk(v, {23'h00_0000, zq[c]});
			get(adr(IDX_GAIN0, c));
			chk(v, {24'h00_0000, gq[c]});
		end
		$display("test trim registers done");
		// boundary trims on channels 0 and 1, boundary data on channel 2
		for (int k = 0; k < 8; k++) begin
			bip = k[0];
			put({IDX_CONFIG, 2'b00}, {31'h0000_0000, bip});
			for (int c = 0; c < 4; c++) begin
				v = rnd();
				dq[c] = v[15:0];
				zq[c] = v[24:16];
				gq[c] = v[31:24];
				if (k < 4 && c == 0) zq[0] = k[1] ? 9'h100 : 9'h0FF;
				if (k < 4 && c == 1) gq[1] = k[1] ? 8'h80 : 8'h7F;
				if (k >= 4 && c == 2) dq[2] = k[1] ? 16'h8000 : 16'hFFFF;
				put(adr(IDX_DATA0, c), {16'h0000, dq[c]});
				put(adr(IDX_ZERO0, c), {23'h00_0000, zq[c]});
				put(adr(IDX_GAIN0, c), {24'h00_0000, gq[c]});
			end
			load <= 1'b1;
			@(posedge mclk);
			load <= 1'b0;
			repeat (3) @(posedge mclk);
			for (int c = 0; c < 4; c++) begin
				chk({13'h0000, code[c]}, exp_code(dq[c], zq[c], gq[c]));
			end
			zq[3] = ~zq[3];
			gq[3] = ~gq[3];
			put(adr(IDX_ZERO0, 3), {23'h00_0000, zq[3]});
			put(adr(IDX_GAIN0, 3), {24'h00_0000, gq[3]});
			repeat (3) @(posedge mclk);
			chk({13'h0000, code[3]}, exp_code(dq[3], zq[3], gq[3]));
			chk({13'h0000, code[0]}, exp_code(dq[0], zq[0], gq[0]));
		end
		$display("test output trims done");
		// corner trims watched by the output assertions; pass 2 drives channel 0 into clamp
		for (int k = 0; k < 3; k++) begin
			bip = k[0];
			put({IDX_CONFIG, 2'b00}, {31'h0000_0000, bip});
			dq = '{16'h0000, 16'h0100, 16'h8000, 16'h4000};
			zq = '{9'h0FF, 9'h100, 9'h000, 9'h000};
			gq = '{8'h00, 8'h00, 8'h80, 8'h7F};
			if (k == 2) begin
				dq[0] = 16'hFFFF;
				gq[0] = 8'h7F;
			end
			for (int c = 0; c < 4; c++) begin
				put(adr(IDX_DATA0, c), {16'h0000, dq[c]});
				put(adr(IDX_ZERO0, c), {23'h00_0000, zq[c]});
				put(adr(IDX_GAIN0, c), {24'h00_0000, gq[c]});
			end
			load <= 1'b1;
			@(posedge mclk);
			load <= 1'b0;
			repeat (3) @(posedge mclk);
			for (int c = 0; c < 4; c++) begin
				chk({13'h0000, code[c]}, exp_code(dq[c], zq[c], gq[c]));
			end
			chk({28'h000_0000, sat}, {28'h000_0000, (k == 2) ? 4'h1 : 4'h0});
		end
		$display("test corner trims done");
		get(6'h38);
		chk(v, 32'h0000_0000);
		chk({30'h0000_0000, r}, {30'h0000_0000, RESP_SLVERR});
		put(6'h11, rnd());
		chk({30'h0000_0000, r}, {30'h0000_0000, RESP_SLVERR});
		$display("test unmapped done");
		close_out();
	end
endmodule : trim_cal_tb_top
